// *** shared/dfp_pkg.sv ***
// Shared constants for the oscillator multiplier programming link
package dfp_pkg;
  // Multiplier format: 10 integer bits over 28 fraction bits
  localparam int MULT_W     = 38;
  localparam int MULT_FRAC  = 28;
  localparam int MULT_INT   = 10;
  localparam int FIELD_W    = 48;
  localparam int MULT_BYTES = 6;
  localparam int KHZ_W      = 24;
  localparam int DVD_W      = MULT_W + 32;

  // Serial port register map
  localparam logic [7:0]         REG_MULT_STD = 8'h07;
  localparam logic [7:0]         REG_MULT_ALT = 8'h0d;
  localparam logic [7:0]         REG_CTRL     = 8'h87;
  localparam logic [7:0]         MULT_SPAN    = 8'h06;
  localparam int                 FREEZE_M_BIT = 5;
  localparam logic [7:0]         FREEZE_M_VAL = 8'h20;
  localparam logic [7:0]         CTRL_CLEAR   = 8'h00;
  localparam logic [7:0]         CTRL_RST     = 8'h00;
  localparam logic [FIELD_W-1:0] FIELDS_RST   = 48'h01c2bc011eb8;
  // Bus address of the oscillator; value is arbitrary
  localparam logic [6:0]         DEV_ADDR     = 7'h55;

  // Divider fields in the top two multiplier bytes
  localparam int         HSD_LSB  = 45;
  localparam int         HSD_W    = 3;
  localparam int         ODIV_LSB = 38;
  localparam int         ODIV_W   = 7;
  localparam logic [3:0] HSD_BASE = 4'h4;

  // Frequencies and tuning window
  localparam longint CLK_HZ       = 100000000;
  localparam longint MHZ          = 1000000;
  localparam longint XTAL_HZ      = 114285000;
  localparam longint XTAL_KHZ     = XTAL_HZ / 1000;
  localparam longint CORE_MIN_MHZ = 4850;
  localparam longint CORE_MAX_MHZ = 5670;
  localparam longint WIN_PPM      = 3500;
  localparam longint PPM_DEN      = 1000000;
  localparam logic [MULT_W-1:0] MULT_MIN = MULT_W'(
    ((CORE_MIN_MHZ * MHZ << MULT_FRAC) + XTAL_HZ - 1) / XTAL_HZ);
  localparam logic [MULT_W-1:0] MULT_MAX = MULT_W'(
    (CORE_MAX_MHZ * MHZ << MULT_FRAC) / XTAL_HZ);

  // Timing
  localparam longint RECAL_MS    = 10;
  localparam int     RECAL_CYC   = int'(RECAL_MS * CLK_HZ / 1000);
  localparam longint SCL_HZ      = 1000000;
  localparam int     SCL_QTR_CYC = int'(CLK_HZ / (4 * SCL_HZ));
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] RD_LAST_FALL = 4'h7;
  localparam logic [6:0] DIV_STEPS    = 7'h46;

  // Controller register map (Avalon byte addresses)
  localparam logic [4:0] HR_CTRL   = 5'h00;
  localparam logic [4:0] HR_FCUR   = 5'h04;
  localparam logic [4:0] HR_FNEW   = 5'h08;
  localparam logic [4:0] HR_STAT   = 5'h0c;
  localparam logic [4:0] HR_OLD_LO = 5'h10;
  localparam logic [4:0] HR_OLD_HI = 5'h14;
  localparam logic [4:0] HR_NEW_LO = 5'h18;
  localparam logic [4:0] HR_NEW_HI = 5'h1c;
endpackage

// *** shared/dfp_link_if.sv ***
// Two-wire serial link between controller and oscillator
`timescale 1ns/1ps
interface dfp_link_if;
  logic scl_o;
  logic scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl_i;
  logic sda_i;

  // Open-drain wires with pull-ups
  assign scl_i = scl_oe ? scl_o : 1'b1;
  assign sda_i = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport host (
    output scl_o, scl_oe, h_sda_o, h_sda_oe,
    input  scl_i, sda_i
  );
  modport dev (
    output d_sda_o, d_sda_oe,
    input  scl_i, sda_i
  );
endinterface

// *** rtl/dfp_host.sv ***
// Controller end: retunes the oscillator multiplier over the serial link
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module dfp_host
  import dfp_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Serial link
  dfp_link_if.host         link
);
  typedef enum logic [2:0] {
    K_START = 3'b000,
    K_STOP  = 3'b001,
    K_WR    = 3'b010,
    K_RD    = 3'b011,
    K_CALC  = 3'b100,
    K_DONE  = 3'b101
  } dfp_kind_e;

  localparam logic [5:0] SQ_RD_LAST = 6'h0a;
  localparam logic [5:0] SQ_ABORT   = 6'h20;

  // Op sequence: read multiplier, compute, freeze, write, unfreeze
  function automatic logic [10:0] op_at(input logic [5:0]  i,
                                        input logic [7:0]  base,
                                        input logic [47:0] nf);
    logic [2:0] k;
    logic [7:0] d;
    logic [5:0] wi;
    k  = K_DONE;
    d  = 8'h00;
    wi = i - 6'h15;
    unique case (i)
      6'h00, 6'h03, 6'h0d, 6'h12, 6'h1c: k = K_START;
      6'h01, 6'h0e, 6'h13, 6'h1d: begin
        k = K_WR;
        d = {DEV_ADDR, 1'b0};
      end
      6'h04: begin
        k = K_WR;
        d = {DEV_ADDR, 1'b1};
      end
      6'h02, 6'h14: begin
        k = K_WR;
        d = base;
      end
      6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a: k = K_RD;
      6'h0b, 6'h11, 6'h1b, 6'h20: k = K_STOP;
      6'h0c: k = K_CALC;
      6'h0f, 6'h1e: begin
        k = K_WR;
        d = REG_CTRL;
      end
      6'h10: begin
        k = K_WR;
        d = FREEZE_M_VAL;
      end
      6'h1f: begin
        k = K_WR;
        d = CTRL_CLEAR;
      end
      6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a: begin
        k = K_WR;
        d = nf[{3'(MULT_BYTES - 1) - wi[2:0], 3'b000} +: 8];
      end
      default: k = K_DONE;
    endcase
    return {k, d};
  endfunction

  logic [31:0]        fcur_q, fnew_q;
  logic               alt_q, busy_q, err_q, nack_q;
  logic [5:0]         si_q;
  logic [1:0]         ph_q;
  logic [3:0]         bit_q;
  logic [FIELD_W-1:0] rx_q;
  logic [MULT_W-1:0]  nmult_q;
  logic [DVD_W-1:0]   dvd_q;
  logic [32:0]        rem_q;
  logic [6:0]         dcnt_q;
  logic               calc_run_q;
  logic [8:0]         tdiv_q;
  logic               sda_m_q, sda_s_q;
  logic               scl_oe_q, sda_oe_q;

  // Register access and decode
  wire logic        req    = read | write;
  wire logic        acc_wr = write & ~waitrequest;
  wire logic        go_wr  = acc_wr & (address == HR_CTRL) & writedata[0];
  wire logic        go     = go_wr & ~busy_q & (fcur_q != 32'h0);
  wire logic        go_bad = go_wr & ~busy_q & (fcur_q == 32'h0);
  wire logic [7:0]  base   = alt_q ? REG_MULT_ALT : REG_MULT_STD;
  wire logic [47:0] nfld   = {rx_q[FIELD_W-1:MULT_W], nmult_q};
  wire logic [10:0] op     = op_at(si_q, base, nfld);
  wire logic [2:0]  kind   = op[10:8];
  wire logic [7:0]  obyte  = op[7:0];
  wire logic        tick   = (tdiv_q == 9'(SCL_QTR_CYC - 1));
  wire logic        is_bus = (kind == K_START) | (kind == K_STOP) |
                             (kind == K_WR) | (kind == K_RD);
  wire logic        in_dat = (bit_q < BYTE_BITS);
  // Data bits from the byte; ack low on every read byte but the last
  wire logic        bit_drv = in_dat ? (kind == K_WR && !obyte[~bit_q[2:0]])
                                     : (kind == K_RD && si_q != SQ_RD_LAST);
  wire logic [32:0] rem_n  = {rem_q[31:0], dvd_q[DVD_W-1]};
  wire logic        q_bit  = (rem_n >= {1'b0, fcur_q});
  wire logic        calc_done = calc_run_q & (dcnt_q == 7'h01);
  wire logic [31:0] rd_mux =
    (address == HR_CTRL)   ? {30'h0, alt_q, 1'b0} :
    (address == HR_FCUR)   ? fcur_q :
    (address == HR_FNEW)   ? fnew_q :
    (address == HR_STAT)   ? {30'h0, err_q, busy_q} :
    (address == HR_OLD_LO) ? rx_q[31:0] :
    (address == HR_OLD_HI) ? {26'h0, rx_q[MULT_W-1:32]} :
    (address == HR_NEW_LO) ? nmult_q[31:0] :
    (address == HR_NEW_HI) ? {26'h0, nmult_q[MULT_W-1:32]} : 32'h0;

  assign link.scl_o    = 1'b0;
  assign link.h_sda_o  = 1'b0;
  assign link.scl_oe   = scl_oe_q;
  assign link.h_sda_oe = sda_oe_q;

  // Bus slave: one wait cycle, then the answer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
      fcur_q      <= 32'h0;
      fnew_q      <= 32'h0;
      alt_q       <= 1'b0;
    end else begin
      waitrequest <= ~(req & waitrequest);
      if (read && waitrequest)
        readdata <= rd_mux;
      if (acc_wr && address == HR_FCUR)
        fcur_q <= writedata;
      if (acc_wr && address == HR_FNEW)
        fnew_q <= writedata;
      if (acc_wr && address == HR_CTRL && !busy_q)
        alt_q <= writedata[1];
    end
  end

  // Quarter-bit divider and sampled data pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tdiv_q  <= 9'h0;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      tdiv_q  <= tick ? 9'h0 : tdiv_q + 9'h1;
      sda_m_q <= link.sda_i;
      sda_s_q <= sda_m_q;
    end
  end

  // New multiplier = old * fnew / fcur, restoring division, full width
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      calc_run_q <= 1'b0;
      dcnt_q     <= 7'h0;
      dvd_q      <= '0;
      rem_q      <= 33'h0;
      nmult_q    <= '0;
    end else if (busy_q && kind == K_CALC && !calc_run_q) begin
      calc_run_q <= 1'b1;
      dcnt_q     <= DIV_STEPS;
      dvd_q      <= DVD_W'(rx_q[MULT_W-1:0] * fnew_q);
      rem_q      <= 33'h0;
    end else if (calc_run_q) begin
      rem_q  <= q_bit ? rem_n - {1'b0, fcur_q} : rem_n;
      dvd_q  <= {dvd_q[DVD_W-2:0], q_bit};
      dcnt_q <= dcnt_q - 7'h1;
      if (calc_done) begin
        calc_run_q <= 1'b0;
        nmult_q    <= {dvd_q[MULT_W-2:0], q_bit};
      end
    end
  end

  // Sequencer and bit engine: read, compute, freeze, write, unfreeze
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q   <= 1'b0;
      err_q    <= 1'b0;
      nack_q   <= 1'b0;
      si_q     <= 6'h0;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      rx_q     <= '0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (go) begin
      busy_q <= 1'b1;
      err_q  <= 1'b0;
      si_q   <= 6'h0;
      ph_q   <= 2'h0;
      bit_q  <= 4'h0;
    end else if (go_bad) begin
      err_q <= 1'b1;
    end else if (busy_q && kind == K_DONE) begin
      busy_q <= 1'b0;
    end else if (busy_q && kind == K_CALC && calc_done) begin
      si_q <= si_q + 6'h1;
    end else if (busy_q && is_bus && tick) begin
      ph_q <= ph_q + 2'h1;
      if (kind == K_START) begin
        if (ph_q == 2'h0) sda_oe_q <= 1'b0;
        if (ph_q == 2'h1) scl_oe_q <= 1'b0;
        if (ph_q == 2'h2) sda_oe_q <= 1'b1;
        if (ph_q == 2'h3) begin
          scl_oe_q <= 1'b1;
          si_q     <= si_q + 6'h1;
        end
      end else if (kind == K_STOP) begin
        if (ph_q == 2'h0) sda_oe_q <= 1'b1;
        if (ph_q == 2'h1) scl_oe_q <= 1'b0;
        if (ph_q == 2'h2) sda_oe_q <= 1'b0;
        if (ph_q == 2'h3) si_q <= si_q + 6'h1;
      end else begin
        if (ph_q == 2'h0) begin
          scl_oe_q <= 1'b1;
          sda_oe_q <= bit_drv;
        end
        if (ph_q == 2'h1) scl_oe_q <= 1'b0;
        if (ph_q == 2'h2 && kind == K_RD && in_dat)
          rx_q <= {rx_q[FIELD_W-2:0], sda_s_q};
        if (ph_q == 2'h2 && kind == K_WR && !in_dat)
          nack_q <= sda_s_q;
        if (ph_q == 2'h3) begin
          scl_oe_q <= 1'b1;
          bit_q    <= in_dat ? bit_q + 4'h1 : 4'h0;
          if (!in_dat && kind == K_WR && nack_q) begin
            err_q    <= 1'b1;
            si_q     <= SQ_ABORT;
            sda_oe_q <= 1'b0;
          end else if (!in_dat) begin
            si_q     <= si_q + 6'h1;
            sda_oe_q <= 1'b0;
          end
        end
      end
    end
  end
endmodule

// *** rtl/dfp_osc_dev.sv ***
// Oscillator end: serial register port and core multiplier control
`timescale 1ns/1ps
module dfp_osc_dev
  import dfp_pkg::*;
#(
  parameter int                 RECAL_CYCLES = RECAL_CYC,
  parameter bit                 HIGH_STAB    = 1'b0,
  parameter logic [FIELD_W-1:0] DEF_FIELDS   = FIELDS_RST
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Serial link
  dfp_link_if.dev          link,
  // Core state
  output logic [MULT_W-1:0] core_mult_q,
  output logic [MULT_W-1:0] center_mult_q,
  output logic              core_run_q,
  output logic              recal_busy_q,
  output logic              freeze_q,
  // Frequencies in kHz
  output logic [KHZ_W-1:0]  core_khz_q,
  output logic [KHZ_W-1:0]  out_khz_q
);
  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_ACK  = 3'b010,
    SL_WR   = 3'b011,
    SL_RD   = 3'b100,
    SL_RACK = 3'b101
  } dfp_sl_e;

  // Window limit: center * 3500 / 1e6
  function automatic logic [MULT_W-1:0] win_lim(input logic [MULT_W-1:0] c);
    logic [63:0] p;
    p = 64'(c) * 64'(WIN_PPM);
    return MULT_W'(p / 64'(PPM_DEN));
  endfunction

  // Core frequency in kHz from the 10.28 multiplier
  function automatic logic [KHZ_W-1:0] to_khz(input logic [MULT_W-1:0] m);
    logic [63:0] p;
    p = 64'(m) * 64'(XTAL_KHZ);
    return KHZ_W'(p >> MULT_FRAC);
  endfunction

  localparam logic [19:0] RECAL_LOAD = 20'(RECAL_CYCLES);

  dfp_sl_e            st_q;
  logic [3:0]         cnt_q;
  logic [7:0]         sh_q, ptr_q, ctrl_q;
  logic               have_ptr_q, rd_q, from_addr_q, nack_q, sda_oe_q;
  logic               scl_m_q, scl_s_q, scl_p_q;
  logic               sda_m_q, sda_s_q, sda_p_q;
  logic [FIELD_W-1:0] fld_q;
  logic [19:0]        recal_q;

  // Link event decode
  wire logic scl_r  = scl_s_q & ~scl_p_q;
  wire logic scl_f  = ~scl_s_q & scl_p_q;
  wire logic st_ev  = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire logic sp_ev  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire logic byte_f = scl_f & (cnt_q == BYTE_BITS);

  // Register window decode
  wire logic [7:0] base   = HIGH_STAB ? REG_MULT_ALT : REG_MULT_STD;
  wire logic [7:0] off    = ptr_q - base;
  wire logic       in_win = (ptr_q >= base) && (off < MULT_SPAN);
  wire logic [2:0] pos    = 3'(MULT_BYTES - 1) - off[2:0];
  wire logic [7:0] rd_now = in_win ? fld_q[{pos, 3'b000} +: 8] :
                            (ptr_q == REG_CTRL) ? ctrl_q : 8'h00;
  wire logic       wr_stb = (st_q == SL_WR) & byte_f & have_ptr_q;

  // Multiplier to apply and its checks
  wire logic [MULT_W-1:0] shadow  = fld_q[MULT_W-1:0];
  wire logic [MULT_W-1:0] delta   = (shadow > center_mult_q)
                                    ? shadow - center_mult_q
                                    : center_mult_q - shadow;
  wire logic in_range = (shadow >= MULT_MIN) && (shadow <= MULT_MAX);
  wire logic in_window = (delta <= win_lim(center_mult_q));
  wire logic apply     = !freeze_q && (shadow != core_mult_q) && in_range &&
                         !recal_busy_q;
  wire logic [3:0]  high_speed_divider  = 4'(fld_q[HSD_LSB +: HSD_W]) + HSD_BASE;
  wire logic [7:0]  out_div = 8'(fld_q[ODIV_LSB +: ODIV_W]) + 8'h01;
  wire logic [11:0] div_all = 12'(high_speed_divider) * 12'(out_div);

  assign link.d_sda_o  = 1'b0;
  assign link.d_sda_oe = sda_oe_q;

  // Pin synchronisers and edge history
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= link.scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= link.sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Serial slave: address, pointer, burst write and burst read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= SL_IDLE;
      cnt_q       <= 4'h0;
      sh_q        <= 8'h00;
      ptr_q       <= 8'h00;
      have_ptr_q  <= 1'b0;
      rd_q        <= 1'b0;
      from_addr_q <= 1'b0;
      nack_q      <= 1'b0;
      sda_oe_q    <= 1'b0;
    end else if (sp_ev) begin
      st_q     <= SL_IDLE;
      sda_oe_q <= 1'b0;
    end else if (st_ev) begin
      st_q     <= SL_ADDR;
      cnt_q    <= 4'h0;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        SL_IDLE: cnt_q <= 4'h0;
        SL_ADDR, SL_WR: begin
          if (scl_r) begin
            sh_q  <= {sh_q[6:0], sda_s_q};
            cnt_q <= cnt_q + 4'h1;
          end
          if (byte_f) begin
            cnt_q       <= 4'h0;
            from_addr_q <= (st_q == SL_ADDR);
            if (st_q == SL_ADDR && sh_q[7:1] != DEV_ADDR) begin
              st_q <= SL_IDLE;
            end else begin
              st_q     <= SL_ACK;
              sda_oe_q <= 1'b1;
            end
            if (st_q == SL_ADDR) begin
              rd_q <= sh_q[0];
              if (!sh_q[0])
                have_ptr_q <= 1'b0;
            end else if (!have_ptr_q) begin
              ptr_q      <= sh_q;
              have_ptr_q <= 1'b1;
            end else begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        SL_ACK: begin
          if (scl_f) begin
            cnt_q <= 4'h0;
            if (rd_q && from_addr_q) begin
              st_q     <= SL_RD;
              sh_q     <= rd_now;
              sda_oe_q <= ~rd_now[7];
              ptr_q    <= ptr_q + 8'h01;
            end else begin
              st_q     <= SL_WR;
              sda_oe_q <= 1'b0;
            end
          end
        end
        SL_RD: begin
          if (scl_f) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == RD_LAST_FALL) begin
              st_q     <= SL_RACK;
              sda_oe_q <= 1'b0;
            end else begin
              sh_q     <= {sh_q[6:0], 1'b0};
              sda_oe_q <= ~sh_q[6];
            end
          end
        end
        SL_RACK: begin
          if (scl_r)
            nack_q <= sda_s_q;
          if (scl_f) begin
            cnt_q <= 4'h0;
            if (nack_q) begin
              st_q <= SL_IDLE;
            end else begin
              st_q     <= SL_RD;
              sh_q     <= rd_now;
              sda_oe_q <= ~rd_now[7];
              ptr_q    <= ptr_q + 8'h01;
            end
          end
        end
        default: st_q <= SL_IDLE;
      endcase
    end
  end

  // Register file; reset restores the factory setting
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fld_q  <= DEF_FIELDS;
      ctrl_q <= CTRL_RST;
    end else if (wr_stb && in_win) begin
      fld_q[{pos, 3'b000} +: 8] <= sh_q;
    end else if (wr_stb && ptr_q == REG_CTRL) begin
      ctrl_q <= sh_q;
    end
  end

  // Core tuning: small moves stay running, large ones recalibrate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_mult_q   <= DEF_FIELDS[MULT_W-1:0];
      center_mult_q <= DEF_FIELDS[MULT_W-1:0];
      core_run_q    <= 1'b1;
      recal_busy_q  <= 1'b0;
      recal_q       <= 20'h0;
      freeze_q      <= 1'b0;
    end else begin
      freeze_q <= ctrl_q[FREEZE_M_BIT];
      if (apply) begin
        core_mult_q <= shadow;
        if (!in_window) begin
          recal_busy_q <= 1'b1;
          core_run_q   <= 1'b0;
          recal_q      <= RECAL_LOAD;
        end
      end else if (recal_busy_q) begin
        recal_q <= recal_q - 20'h1;
        if (recal_q == 20'h1) begin
          recal_busy_q  <= 1'b0;
          core_run_q    <= 1'b1;
          center_mult_q <= core_mult_q;
        end
      end
    end
  end

  // Frequency report
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_khz_q <= '0;
      out_khz_q  <= '0;
    end else begin
      core_khz_q <= to_khz(core_mult_q);
      out_khz_q  <= KHZ_W'(core_khz_q / div_all);
    end
  end
endmodule

// *** test/dfp_asserts.sv ***
// Property checks on the serial link, bus handshake and oscillator core
`timescale 1ns/1ps
module dfp_asserts
  import dfp_pkg::*;
#(
  parameter int RECAL_CYCLES = RECAL_CYC
) (
  // Clock and reset
  input wire logic              clock,
  input wire logic              rst_n,
  // Link and bus
  input wire logic              scl_i,
  input wire logic              d_sda_oe,
  input wire logic              read,
  input wire logic              write,
  input wire logic              waitrequest,
  // Core state
  input wire logic [MULT_W-1:0] core_mult_q,
  input wire logic [MULT_W-1:0] center_mult_q,
  input wire logic              core_run_q,
  input wire logic              recal_busy_q,
  input wire logic              freeze_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [31:0] busy_cnt_q;
  logic [63:0] diff;
  logic        win_ok;

  // Distance of the applied multiplier from the current center
  assign diff = (core_mult_q > center_mult_q) ?
                64'(core_mult_q - center_mult_q) :
                64'(center_mult_q - core_mult_q);
  assign win_ok = diff * 64'(PPM_DEN) <= 64'(center_mult_q) * 64'(WIN_PPM);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= recal_busy_q ? busy_cnt_q + 32'h1 : '0;
  end

  sequence s_req;
    (read || write) && waitrequest;
  endsequence

  AST_WAIT_ANSWER: assert property (s_req |=> !waitrequest)
    else $error("bus request not answered next cycle");
  AST_WAIT_STANDS: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_CORE_RANGE: assert property (
    core_mult_q >= MULT_MIN && core_mult_q <= MULT_MAX)
    else $error("core multiplier outside oscillator range");
  AST_FREEZE_HOLD: assert property (
    freeze_q && $past(freeze_q) |-> $stable(core_mult_q))
    else $error("core multiplier moved while frozen");
  AST_RUN_BUSY: assert property (core_run_q != recal_busy_q)
    else $error("core run and recalibration disagree");
  AST_RECAL_LEN: assert property (
    recal_busy_q |-> busy_cnt_q < RECAL_CYCLES)
    else $error("recalibration too long");
  AST_CENTER_MOVE: assert property (
    !$stable(center_mult_q) |-> $past(recal_busy_q))
    else $error("center moved without recalibration");
  AST_SMALL_RUN: assert property (
    $changed(core_mult_q) && win_ok && !recal_busy_q
    |=> !recal_busy_q [*3])
    else $error("small retune stopped the core");
  AST_LARGE_RECAL: assert property (
    $changed(core_mult_q) && !win_ok |-> ##[0:4] recal_busy_q)
    else $error("large retune without recalibration");
  AST_DEV_SDA: assert property ($changed(d_sda_oe) |-> !scl_i)
    else $error("oscillator moved data line while clock high");
endmodule

// *** test/tb_dco_frequency_programming.sv ***
// Testbench: controller and oscillator joined over the serial link
`timescale 1ns/1ps
module tb_dco_frequency_programming
  import dfp_pkg::*;
;
  localparam int                RCY   = 20;
  localparam logic [MULT_W-1:0] DEF_M = 38'h2bc011eb8;

  logic              clock;
  logic              rst_n;
  logic              read;
  logic              write;
  logic              waitrequest;
  logic [4:0]        address;
  logic [31:0]       writedata;
  logic [31:0]       readdata;
  logic [31:0]       rd;
  logic [MULT_W-1:0] core_mult_q;
  logic [MULT_W-1:0] center_mult_q;
  logic [MULT_W-1:0] m_old;
  logic [MULT_W-1:0] m_new;
  logic [MULT_W-1:0] m_rd;
  logic [63:0]       khz;
  logic              core_run_q;
  logic              recal_busy_q;
  logic              freeze_q;
  logic [KHZ_W-1:0]  core_khz_q;
  logic [KHZ_W-1:0]  out_khz_q;
  int                n_fail;
  int                num_checks;

  dfp_link_if lnk();
  dfp_host dfp_host_inst (.clock, .rst_n, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .link(lnk));
  dfp_osc_dev #(.RECAL_CYCLES(RCY)) dfp_osc_dev_inst (.clock, .rst_n,
    .link(lnk), .core_mult_q, .center_mult_q, .core_run_q, .recal_busy_q,
    .freeze_q, .core_khz_q, .out_khz_q);
  dfp_asserts #(.RECAL_CYCLES(RCY)) dfp_asserts_inst (.clock, .rst_n,
    .scl_i(lnk.scl_i), .d_sda_oe(lnk.d_sda_oe), .read, .write,
    .waitrequest, .core_mult_q, .center_mult_q, .core_run_q,
    .recal_busy_q, .freeze_q);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    for (i = 0; i < 100; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0)
        break;
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 100) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic rd_mult(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
    m_rd[31:0] = rd;
    bus(1'b0, a + 5'h04, 32'h0);
    m_rd[37:32] = rd[5:0];
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 10000; i++) begin
      bus(1'b0, HR_STAT, 32'h0);
      if (rd[0] === 1'b0)
        break;
    end
    if (i == 10000) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic retune(input logic [31:0] fc, input logic [31:0] fn);
    m_new = MULT_W'(64'(m_old) * 64'(fn) / 64'(fc));
    bus(1'b1, HR_FCUR, fc);
    bus(1'b1, HR_FNEW, fn);
    bus(1'b1, HR_CTRL, 32'h1);
    bus(1'b0, HR_STAT, 32'h0);
    chk(rd[1:0], 2'h1);
    wait_idle();
    rd_mult(HR_OLD_LO);
    chk(m_rd, m_old);
    rd_mult(HR_NEW_LO);
    chk(m_rd, m_new);
    chk(core_mult_q, m_new);
  endtask

  initial begin
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    chk(core_mult_q, DEF_M);
    bus(1'b1, HR_CTRL, 32'h2);
    bus(1'b0, HR_CTRL, 32'h0);
    chk(rd[1], 1'b1);
    bus(1'b1, HR_CTRL, 32'h0);
    bus(1'b0, 5'h01, 32'h0);
    chk(rd, 32'h0);
    // Zero current frequency is refused with an error
    bus(1'b1, HR_FCUR, 32'h0);
    bus(1'b1, HR_CTRL, 32'h1);
    wait_idle();
    chk(rd[1:0], 2'h2);
    m_old = DEF_M;
    retune(32'h2437e, 32'h24414);
    chk(center_mult_q, DEF_M);
    chk(core_run_q, 1'b1);
    m_old = m_new;
    retune(32'h2625a, 32'h2756d);
    repeat (RCY + 10) @(posedge clock);
    chk(center_mult_q, m_new);
    chk(core_run_q, 1'b1);
    chk(freeze_q, 1'b0);
    khz = (64'(m_new) * 64'(XTAL_KHZ)) >> MULT_FRAC;
    chk(core_khz_q, khz);
    chk(out_khz_q, khz / 64'h20);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk(core_mult_q, DEF_M);
    chk(center_mult_q, DEF_M);
    finish_test();
  end
endmodule
